// File: rtl/tft_pkg.sv
/*
 package for the time frame transmitter: bit timing, frame layout,
 register offsets, field positions and reset values.
 assumes a single 100 MHz clock and an APB register bus with 32-bit data.
*/
package tft_pkg;

   // ----------------------------------------------------------------
   // clock and bit timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   localparam int BIT_RATE_HZ = 1_000_000;
   localparam int BIT_CYCLES = CLK_HZ / BIT_RATE_HZ;
   localparam int ZERO_HIGH_NS = 250;
   localparam int ONE_HIGH_NS = 750;
   localparam int ZERO_HIGH_CYC = (ZERO_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ONE_HIGH_CYC = (ONE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_BITS = 1000;
   localparam int FRAMES_PER_SEC = 1000;
   localparam int SYNC_BITS = 48;
   localparam int MS_SYNC_ONES = 31;
   localparam int SEC_SYNC_ONES = 47;
   localparam int MS_ZERO_FILL = SYNC_BITS - MS_SYNC_ONES - 1;
   localparam int WORD_BITS = 17;
   localparam int DATA_BITS = 16;
   localparam int FRAME_WORDS = 56;
   localparam int DATA_WORDS = 55;
   localparam int TIME_WORDS = 4;
   localparam int STATUS_WORD = 54;
   localparam int CRC_WORD = 55;
   localparam int STATUS_BITS = 5;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_CRC_POLY = 12'h004;
   localparam logic [11:0] REG_CRC_PRESET = 12'h008;
   localparam logic [11:0] REG_TIME_LO = 12'h00c;
   localparam logic [11:0] REG_TIME_HI = 12'h010;
   localparam logic [11:0] REG_STATE = 12'h014;
   localparam logic [11:0] REG_ATOMIC_LO = 12'h018;
   localparam logic [11:0] REG_ATOMIC_HI = 12'h01c;
   localparam logic [3:0] BUF_PAGE = 4'h1;
   localparam int CTRL_SRC_BIT = 0;
   localparam int CTRL_LOAD_BIT = 1;
   localparam logic [15:0] CRC_POLY_RST = 16'h1021;
   localparam logic [15:0] CRC_PRESET_RST = 16'hffff;

endpackage : tft_pkg

// File: rtl/tft_time_frame_transmitter.sv
/*
 time frame transmitter: builds a 1000-bit frame every millisecond and
 sends it as a pulse-width-modulated 1 MHz clock bus, with a double
 buffer filled over APB, a 64-bit microsecond counter and a frame crc.
 assumes presetn comes only from power-up or the dedicated reset switch,
 and that status condition pins are asynchronous to pclk.
*/
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps

// Notes on behaviour
// - one frame per millisecond, fifty-five data words of sixteen bits.
// - words past four come from buffer filled last frame; first four selectable.
// - millisecond marker is zeros, thirty-one ones, then one zero.
// - second marker is forty-seven ones then one zero.
// - 1 MHz pwm carrier; rising edge is bit clock, width gives value.
// - every frame is exactly one thousand bit periods.
// - each word is sixteen data bits plus one zero stop bit.
// - fifty-six words, forty-eight sync bits; zero fill leads millisecond sync.
// - word fifty-five carries crc over all bits since frame start.
// - words zero to three carry atomic microsecond count, low half first.
// - words four to seven carry utc and sidereal millisecond counts.
// - words nine to sixteen carry packed decimal times and date.
// - words seventeen to twenty carry month and weekday names and numbers.
// - word 22 offsets byte pair; word 27 signed rotation offset.
// - words 25, 26 carry binary tick phase with valid flag on top.
// - words 23, 24 carry decimal tick phase with valid flag on top.
// - status word bits zero to four report the five alarm conditions.
// - time logic resets only on power-up or reset switch.
// - counter-sourced atomic time keeps going out while host resets.
module tft_time_frame_transmitter (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // alarm condition pins
   input wire logic [tft_pkg::STATUS_BITS-1:0] status_cond_in,
   // clock bus
   output logic clock_bus_out
);
   import tft_pkg::*;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic din,
                                            input logic [15:0] poly);
      logic fb;
      fb = crc[15] ^ din;
      crc_step = {crc[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
   endfunction : crc_step

   // ---------------------------------------------------------------
   // condition pin synchroniser
   // ---------------------------------------------------------------
   logic [STATUS_BITS-1:0] cond_meta;
   logic [STATUS_BITS-1:0] cond_sync;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cond_meta <= '0;
         cond_sync <= '0;
      end else begin
         cond_meta <= status_cond_in;
         cond_sync <= cond_meta;
      end
   end

   // ---------------------------------------------------------------
   // bit and frame counters
   // ---------------------------------------------------------------
   logic [6:0] cyc_cnt;
   logic [9:0] bit_idx;
   logic [5:0] word_idx;
   logic [4:0] slot_idx;
   logic [9:0] ms_cnt;

   wire bit_tick = (cyc_cnt == 7'(BIT_CYCLES - 1));
   wire frame_end = bit_tick && (bit_idx == 10'(FRAME_BITS - 1));
   wire in_sync = (bit_idx < 10'(SYNC_BITS));
   wire sec_frame = (ms_cnt == 10'h000);
   wire slot_last = (slot_idx == 5'(WORD_BITS - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_cnt <= '0;
      end else if (bit_tick) begin
         cyc_cnt <= '0;
      end else begin
         cyc_cnt <= cyc_cnt + 7'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_idx <= '0;
         word_idx <= '0;
         slot_idx <= '0;
      end else if (frame_end) begin
         bit_idx <= '0;
         word_idx <= '0;
         slot_idx <= '0;
      end else if (bit_tick) begin
         bit_idx <= bit_idx + 10'h001;
         if (!in_sync) begin
            slot_idx <= slot_last ? 5'h00 : slot_idx + 5'h01;
            word_idx <= slot_last ? word_idx + 6'h01 : word_idx;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt <= '0;
      end else if (frame_end) begin
         ms_cnt <= (ms_cnt == 10'(FRAMES_PER_SEC - 1)) ? 10'h000 : ms_cnt + 10'h001;
      end
   end

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   wire apb_setup = psel && !penable;
   wire apb_write = psel && penable && pready && pwrite;
   wire word_al = (paddr[1:0] == 2'b00);
   wire hit_ctrl = (paddr == REG_CTRL);
   wire hit_poly = (paddr == REG_CRC_POLY);
   wire hit_preset = (paddr == REG_CRC_PRESET);
   wire hit_tlo = (paddr == REG_TIME_LO);
   wire hit_thi = (paddr == REG_TIME_HI);
   wire hit_state = (paddr == REG_STATE);
   wire hit_alo = (paddr == REG_ATOMIC_LO);
   wire hit_ahi = (paddr == REG_ATOMIC_HI);
   wire [5:0] buf_idx = paddr[7:2];
   wire hit_buf = (paddr[11:8] == BUF_PAGE) && word_al && (buf_idx < 6'(FRAME_WORDS));
   wire addr_ok = hit_ctrl || hit_poly || hit_preset || hit_tlo || hit_thi || hit_state ||
                  hit_alo || hit_ahi || hit_buf;

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   logic src_buffer;
   logic time_load;
   logic [15:0] crc_poly;
   logic [15:0] crc_preset;
   logic [63:0] time_stage;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_buffer <= 1'b0;
         time_load <= 1'b0;
         crc_poly <= CRC_POLY_RST;
         crc_preset <= CRC_PRESET_RST;
         time_stage <= '0;
      end else begin
         time_load <= apb_write && hit_ctrl && pwdata[CTRL_LOAD_BIT];
         if (apb_write && hit_ctrl) begin
            src_buffer <= pwdata[CTRL_SRC_BIT];
         end
         if (apb_write && hit_poly) begin
            crc_poly <= pwdata[15:0];
         end
         if (apb_write && hit_preset) begin
            crc_preset <= pwdata[15:0];
         end
         if (apb_write && hit_tlo) begin
            time_stage[31:0] <= pwdata;
         end
         if (apb_write && hit_thi) begin
            time_stage[63:32] <= pwdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // atomic microsecond counter
   // ---------------------------------------------------------------
   logic [63:0] atomic_microsecond_count;
   logic [63:0] time_snap;
   logic [63:0] next_atomic;

   // only presetn clears it; no bus activity stops the count
   assign next_atomic = time_load ? time_stage :
                        (bit_tick ? atomic_microsecond_count + 64'h1 : atomic_microsecond_count);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         atomic_microsecond_count <= '0;
         time_snap <= '0;
      end else begin
         atomic_microsecond_count <= next_atomic;
         if (frame_end) begin
            time_snap <= next_atomic;
         end
      end
   end

   // ---------------------------------------------------------------
   // double frame buffer
   // ---------------------------------------------------------------
   logic [15:0] frame_buf [2][FRAME_WORDS];
   logic active_bank;

   // cleared so that unwritten words go out as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_buf <= '{default: 16'h0000};
      end else if (apb_write && hit_buf) begin
         frame_buf[!active_bank][buf_idx] <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_bank <= 1'b0;
      end else if (frame_end) begin
         active_bank <= !active_bank;
      end
   end

   // ---------------------------------------------------------------
   // word and bit selection
   // ---------------------------------------------------------------
   logic [15:0] crc_reg;
   wire [15:0] buf_word = frame_buf[active_bank][word_idx];
   wire use_time = (word_idx < 6'(TIME_WORDS)) && !src_buffer;
   wire [15:0] time_word = time_snap[{word_idx[1:0], 4'h0} +: 16];
   wire is_status = (word_idx == 6'(STATUS_WORD));
   wire is_crc = (word_idx == 6'(CRC_WORD));
   // words 4..53 pass from the host buffer unchanged
   wire [15:0] word_data = is_crc ? crc_reg :
                           use_time ? time_word :
                           is_status ? {buf_word[15:STATUS_BITS], cond_sync} :
                           buf_word;
   wire [3:0] data_pos = 4'(DATA_BITS - 1) - slot_idx[3:0];
   wire data_bit = (slot_idx < 5'(DATA_BITS)) ? word_data[data_pos] : 1'b0;
   wire ms_sync_bit = (bit_idx >= 10'(MS_ZERO_FILL)) &&
                      (bit_idx < 10'(MS_ZERO_FILL + MS_SYNC_ONES));
   wire sec_sync_bit = (bit_idx < 10'(SEC_SYNC_ONES));
   wire tx_bit = in_sync ? (sec_frame ? sec_sync_bit : ms_sync_bit) : data_bit;
   // bit value frozen for the whole period: no second rise inside a bit
   logic bit_hold;
   wire line_bit = (cyc_cnt == 7'h00) ? tx_bit : bit_hold;
   wire [6:0] high_len = line_bit ? 7'(ONE_HIGH_CYC) : 7'(ZERO_HIGH_CYC);

   // ---------------------------------------------------------------
   // frame crc
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_reg <= CRC_PRESET_RST;
      end else if (frame_end) begin
         crc_reg <= crc_preset;
      end else if (bit_tick && !is_crc) begin
         crc_reg <= crc_step(crc_reg, line_bit, crc_poly);
      end
   end

   // ---------------------------------------------------------------
   // pwm line driver
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_bus_out <= 1'b0;
         bit_hold <= 1'b0;
      end else begin
         clock_bus_out <= (cyc_cnt < high_len);
         bit_hold <= line_bit;
      end
   end

   // ---------------------------------------------------------------
   // apb answer
   // ---------------------------------------------------------------
   wire [31:0] state_word = {6'h00, bit_idx, cond_sync, active_bank, ms_cnt};
   wire [31:0] read_mux = hit_ctrl ? {31'h0, src_buffer} :
                          hit_poly ? {16'h0000, crc_poly} :
                          hit_preset ? {16'h0000, crc_preset} :
                          hit_tlo ? time_stage[31:0] :
                          hit_thi ? time_stage[63:32] :
                          hit_state ? state_word :
                          hit_alo ? atomic_microsecond_count[31:0] :
                          hit_ahi ? atomic_microsecond_count[63:32] :
                          32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup && !addr_ok;
         prdata <= (apb_setup && !pwrite) ? read_mux : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_frame_wrap_length: assert property (frame_end |=> (bit_idx == 0) && (cyc_cnt == 0))
      else $error("frame did not wrap after 1000 bits");

   a_ms_count_step: assert property (frame_end && ms_cnt != 999 |=> ms_cnt == $past(ms_cnt) + 1)
      else $error("millisecond count did not advance");

   a_bit_rise_edge: assert property (cyc_cnt == 0 |=> clock_bus_out)
      else $error("bus not high at start of bit");

   a_zero_pulse_width: assert property (cyc_cnt == ZERO_HIGH_CYC && !line_bit |=> !clock_bus_out)
      else $error("zero pulse too long");

   a_one_pulse_width: assert property (cyc_cnt == ONE_HIGH_CYC - 1 && line_bit |=> clock_bus_out ##1 !clock_bus_out)
      else $error("one pulse width wrong");

   a_stop_bit_zero: assert property (!in_sync && slot_idx == 16 |-> !tx_bit)
      else $error("stop bit not zero");

   a_ms_sync_shape: assert property (in_sync && !sec_frame |->
                                     tx_bit == (bit_idx >= 16 && bit_idx < 47))
      else $error("millisecond sync pattern wrong");

   a_sec_sync_shape: assert property (in_sync && sec_frame |-> tx_bit == (bit_idx < 47))
      else $error("second sync pattern wrong");

   a_words_per_frame: assert property (frame_end |-> word_idx == 55 && slot_idx == 16)
      else $error("frame does not end on last word stop bit");

   a_crc_word_hold: assert property (is_crc && bit_tick && !frame_end |=> crc_reg == $past(crc_reg))
      else $error("crc changed while being sent");

   a_crc_preset_load: assert property (frame_end |=> crc_reg == $past(crc_preset))
      else $error("crc not preset at frame start");

   a_time_word_source: assert property (!in_sync && word_idx == 3 && !src_buffer |->
                                        word_data == time_snap[63:48])
      else $error("atomic time word 3 wrong");

   a_bank_swap: assert property (frame_end |=> active_bank != $past(active_bank))
      else $error("buffer bank not swapped");

   a_atomic_advance: assert property (bit_tick && !time_load |=>
                                      atomic_microsecond_count == $past(atomic_microsecond_count) + 1)
      else $error("atomic count did not advance");

   a_status_bits: assert property (is_status && !src_buffer |-> word_data[4:0] == cond_sync)
      else $error("status word bits wrong");

   a_single_rise_bit: assert property ($rose(clock_bus_out) |-> cyc_cnt == 7'h01)
      else $error("bus rose away from bit start");

   a_word_step: assert property (bit_tick && !in_sync && slot_last && !frame_end |=>
                                 slot_idx == 5'h00 && word_idx == $past(word_idx) + 1)
      else $error("word did not advance after stop bit");

   a_sync_to_words: assert property (bit_tick && bit_idx == 10'(SYNC_BITS - 1) |=>
                                     !in_sync && word_idx == 6'h00 && slot_idx == 5'h00)
      else $error("words did not start after sync");

   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");

endmodule : tft_time_frame_transmitter

// File: verification/tb.sv
/*
 testbench for the time frame transmitter: register table over apb,
 then decodes the clock bus through the receiver model and checks two
 frame markers, word order, stop bits and buffer contents.
 assumes the package constants and a 100 MHz clock.
*/
`timescale 1ns/1ps

module tb;
   import tft_pkg::*;

   // ----------------------------------------------------------------
   // stimulus table and signals
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic [11:0] addr;
      logic [31:0] wdata;
      logic [31:0] exp;
      logic err;
   } tft_row_s;
   localparam int NROWS = 12;
   localparam int F1 = FRAME_BITS;
   localparam int B1 = F1 + SYNC_BITS;
   localparam int NEED = B1 + 6 * WORD_BITS;
   localparam int CRC_AT = SYNC_BITS + CRC_WORD * WORD_BITS;
   tft_row_s rows [NROWS] = '{
      '{1'b0, REG_CRC_POLY, 32'h0, 32'h0000_1021, 1'b0},
      '{1'b0, REG_CRC_PRESET, 32'h0, 32'h0000_ffff, 1'b0},
      '{1'b1, REG_CRC_POLY, 32'h0000_8005, 32'h0, 1'b0},
      '{1'b0, REG_CRC_POLY, 32'h0, 32'h0000_8005, 1'b0},
      '{1'b1, REG_CRC_POLY, 32'h0000_1021, 32'h0, 1'b0},
      '{1'b1, REG_TIME_LO, 32'h0, 32'h0, 1'b0},
      '{1'b1, REG_TIME_HI, 32'h0123_4567, 32'h0, 1'b0},
      '{1'b0, REG_TIME_HI, 32'h0, 32'h0123_4567, 1'b0},
      '{1'b0, REG_CTRL, 32'h0, 32'h0, 1'b0},
      '{1'b0, 12'h020, 32'h0, 32'h0, 1'b1},
      '{1'b1, 12'h024, 32'h0000_ffff, 32'h0, 1'b1},
      '{1'b0, 12'h002, 32'h0, 32'h0, 1'b1}
   };
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [STATUS_BITS-1:0] status_cond_in = 5'h00;
   logic clock_bus_out;
   logic bit_stb;
   logic bit_val;
   logic rise_stb;
   logic [7:0] width;
   logic [7:0] period;
   logic rx [0:1199];
   int nbits = 0;
   int bad_count = 0;
   int checks_done = 0;

   always #5 pclk = ~pclk;

   tft_time_frame_transmitter i_dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .status_cond_in(status_cond_in), .clock_bus_out(clock_bus_out)
   );

   tft_bus_receiver i_rx (
      .pclk(pclk), .presetn(presetn), .bus_in(clock_bus_out), .bit_stb(bit_stb),
      .bit_val(bit_val), .rise_stb(rise_stb), .width(width), .period(period)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         chk(1'b0, "no ready");
      end
   endtask : apb

   function automatic logic run_is(input int from, input int len, input logic v);
      logic ok;
      ok = 1'b1;
      for (int i = from; i < from + len; i++) begin
         if (rx[i] !== v) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction : run_is

   function automatic logic [15:0] word_at(input int b);
      logic [15:0] w;
      w = 16'h0000;
      for (int i = 0; i < DATA_BITS; i++) begin
         w = {w[14:0], rx[b + i]};
      end
      return w;
   endfunction : word_at

   function automatic logic [15:0] crc_of(input int len);
      logic [15:0] c;
      c = CRC_PRESET_RST;
      for (int i = 0; i < len; i++) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ rx[i]) ? CRC_POLY_RST : 16'h0000);
      end
      return c;
   endfunction : crc_of

   task automatic test_done;
      $display("checks %0d, errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   // ----------------------------------------------------------------
   // bus collector and watchdog
   // ----------------------------------------------------------------
   always @(posedge pclk) begin
      if (bit_stb && nbits < 1200) begin
         rx[nbits] = bit_val;
         nbits = nbits + 1;
      end
      if (rise_stb && nbits > 0) begin
         chk(period === 8'(BIT_CYCLES), "bit period");
         chk((width === 8'(ZERO_HIGH_CYC) && rx[nbits-1] === 1'b0) ||
             (width === 8'(ONE_HIGH_CYC) && rx[nbits-1] === 1'b1), "pulse width");
      end
   end

   initial begin
      #1_300_000;
      bad_count++;
      $display("Error at %0t: watchdog", $time);
      test_done();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] rd;
      logic er;
      logic [15:0] w;
      int guard;
      repeat (3) @(posedge pclk);
      chk(clock_bus_out === 1'b0 && pready === 1'b0 && pslverr === 1'b0 && prdata === 32'h0, "reset outputs");
      presetn <= 1'b1;
      for (int r = 0; r < NROWS; r++) begin
         apb(rows[r].wr, rows[r].addr, rows[r].wdata, rd, er);
         chk(er === rows[r].err, "response code");
         if (!rows[r].wr) begin
            chk(rd === rows[r].exp, "read data");
         end
      end
      status_cond_in <= 5'h15;
      repeat (4) @(posedge pclk);
      apb(1'b0, REG_STATE, 32'h0, rd, er);
      chk(rd[15:11] === 5'h15, "alarm bits");
      apb(1'b1, REG_CTRL, 32'h0000_0002, rd, er);
      apb(1'b0, REG_ATOMIC_HI, 32'h0, rd, er);
      chk(rd === 32'h0123_4567, "loaded count");
      apb(1'b0, REG_CTRL, 32'h0, rd, er);
      chk(rd === 32'h0, "control readback");
      for (int n = TIME_WORDS; n < FRAME_WORDS - 1; n++) begin
         apb(1'b1, {BUF_PAGE, 8'(4 * n)}, {16'h0000, 16'ha500 + 16'(n)}, rd, er);
         chk(er === 1'b0, "buffer write");
      end
      guard = 0;
      while (nbits < NEED && guard < 130000) begin
         @(posedge pclk);
         guard++;
      end
      chk(run_is(0, SEC_SYNC_ONES, 1'b1) && rx[SEC_SYNC_ONES] === 1'b0, "second marker");
      w = word_at(SYNC_BITS);
      chk((w === 16'h0000 || w === 16'h0001) && word_at(SYNC_BITS + 3 * WORD_BITS) === 16'h0000, "start count");
      for (int k = 0; k < 6; k++) begin
         chk(rx[SYNC_BITS + k * WORD_BITS + 16] === 1'b0 && rx[B1 + k * WORD_BITS + 16] === 1'b0, "stop bit");
      end
      chk(run_is(F1, MS_ZERO_FILL, 1'b0) && run_is(F1 + MS_ZERO_FILL, MS_SYNC_ONES, 1'b1)
          && rx[B1 - 1] === 1'b0, "ms marker");
      w = word_at(B1);
      chk(w >= 16'h03de && w <= 16'h03e8, "count low word");
      chk(word_at(B1 + WORD_BITS) === 16'h0000 && word_at(B1 + 2 * WORD_BITS) === 16'h4567
          && word_at(B1 + 3 * WORD_BITS) === 16'h0123, "count order");
      chk(word_at(B1 + 4 * WORD_BITS) === 16'ha504 && word_at(B1 + 5 * WORD_BITS) === 16'ha505, "buffer words");
      chk(word_at(SYNC_BITS + STATUS_WORD * WORD_BITS) === 16'h0015, "status word");
      chk(word_at(CRC_AT) === crc_of(CRC_AT), "crc word");
      test_done();
   end

endmodule : tb

// File: verification/tft_bus_receiver.sv
/*
 receiver model of a downstream accessory on the pwm clock bus: finds
 rising edges, samples the level at mid-period, reports bit values,
 high-pulse widths and edge-to-edge periods.
 assumes it runs on the device clock and watches the bus after reset.
*/
`timescale 1ns/1ps

module tft_bus_receiver (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // clock bus
   input wire logic bus_in,
   // decoded bits
   output logic bit_stb,
   output logic bit_val,
   // edge timing
   output logic rise_stb,
   output logic [7:0] width,
   output logic [7:0] period
);

   // ----------------------------------------------------------------
   // edge finder and mid-period decoder
   // ----------------------------------------------------------------
   logic prev;
   logic started;
   logic [7:0] cnt;
   logic [7:0] hi;
   wire rise = bus_in && !prev;
   wire mid = started && (cnt == 8'd50);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= 1'b0;
         started <= 1'b0;
         cnt <= 8'h00;
         hi <= 8'h00;
         bit_stb <= 1'b0;
         bit_val <= 1'b0;
         rise_stb <= 1'b0;
         width <= 8'h00;
         period <= 8'h00;
      end else begin
         prev <= bus_in;
         rise_stb <= rise;
         bit_stb <= mid;
         if (mid) begin
            bit_val <= bus_in;
         end
         if (rise) begin
            width <= hi;
            period <= cnt;
            cnt <= 8'h01;
            hi <= 8'h01;
            started <= 1'b1;
         end else begin
            cnt <= cnt + 8'h01;
            hi <= hi + {7'h00, bus_in};
         end
      end
   end

endmodule : tft_bus_receiver
